// ==== src/trs_consts.svh ====
`ifndef TRS_CONSTS_SVH
`define TRS_CONSTS_SVH

// ----------------------------------------------------------------
// clock and timing base
// ----------------------------------------------------------------
`define TRS_CLK_HZ           40000000
`define TRS_TICK_US          1000
`define TRS_TICK_CYCLES      (`TRS_CLK_HZ / 1000000 * `TRS_TICK_US)
`define TRS_DEBOUNCE_US      1500
`define TRS_DEBOUNCE_CYCLES  (`TRS_CLK_HZ / 1000000 * `TRS_DEBOUNCE_US)
`define TRS_FILTER_US        2000
`define TRS_FILTER_CYCLES    (`TRS_CLK_HZ / 1000000 * `TRS_FILTER_US)

// ----------------------------------------------------------------
// counter widths
// ----------------------------------------------------------------
`define TRS_CNT_W            17
`define TRS_MS_W             10

// ----------------------------------------------------------------
// first release delay in ms ticks, and multipliers
// ----------------------------------------------------------------
`define TRS_D1_LOW_MS        10'h00F
`define TRS_D1_OPEN_MS       10'h01E
`define TRS_D1_HIGH_MS       10'h04B
`define TRS_D2_MULT          10'h005
`define TRS_D3_MULT          10'h00A
`define TRS_MS_ZERO          10'h000

`endif

// ==== src/trs_pkg.sv ====
package trs_pkg;

    // ------------------------------------------------------------
    // three-state pin level: low, high, left open
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TRS_TRI_LOW,
        TRS_TRI_HIGH,
        TRS_TRI_OPEN
    } trs_tri_t;

    // ------------------------------------------------------------
    // latched supply tolerance window
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TRS_TOL_5,
        TRS_TOL_10,
        TRS_TOL_15
    } trs_tol_t;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TRS_ST_HOLD,
        TRS_ST_MANUAL,
        TRS_ST_WAIT,
        TRS_ST_RUN
    } trs_state_t;

    typedef struct packed {
        logic first_reset_n;
        logic second_reset_n;
        logic third_reset_n;
    } trs_resets_t;

endpackage : trs_pkg

// ==== src/trs_sequencer.sv ====
`timescale 1ns/1ps
`include "trs_consts.svh"

// What this block does
// - filtered supply fault drives all three reset outputs low together
// - first reset stays low for the selected delay after supply recovers
// - second and third resets release later, each after its longer delay
// - released outputs stay high until a fault or pushbutton reset
// - power-up holds all resets low, then runs the same sequence
// - tolerance select sampled only while supply below lowest trip level
// - tolerance decode: high 5%, low 10%, open 15%
// - pushbutton accepted whenever any reset output is high
// - held pushbutton keeps all three resets low
// - pushbutton release starts the sequenced release
// - pushbutton is debounced internally against contact bounce
// - delay select decoded from low, high or open
// - first delay at least 10, 20 or 50 ms for low, open, high
// - all three release delays come from one tick divider chain
// - second delay five times first, third ten times first
// - first delay at most 20, 40 or 100 ms
// - stable-low pushbutton asserts resets within 1.0 to 2.0 ms
// - supply dips of 2 ms or less cause no reset
module trs_sequencer #(
    parameter int TICK_CYCLES     = `TRS_TICK_CYCLES,
    parameter int DEBOUNCE_CYCLES = `TRS_DEBOUNCE_CYCLES,
    parameter int FILTER_CYCLES   = `TRS_FILTER_CYCLES
) (
    input  wire logic             CORE_CLK_I,
    input  wire logic             RESET_N_I,
    input  wire logic             SUPPLY_FAULT_I,
    input  wire logic             SUPPLY_BELOW_MIN_I,
    input  wire logic             MANUAL_RESET_N_I,
    input  wire trs_pkg::trs_tri_t DELAY_SELECT_I,
    input  wire trs_pkg::trs_tri_t TOLERANCE_SELECT_I,
    output trs_pkg::trs_tol_t     TOLERANCE_WINDOW_O,
    output trs_pkg::trs_resets_t  RESETS_N_O
);
    import trs_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // an undefined code reads as open: the middle delay, and the 15% tolerance window
    function automatic trs_tri_t tri_decode(input trs_tri_t raw);
        if (raw == TRS_TRI_LOW) begin
            return TRS_TRI_LOW;
        end else if (raw == TRS_TRI_HIGH) begin
            return TRS_TRI_HIGH;
        end
        return TRS_TRI_OPEN;
    endfunction : tri_decode

    function automatic logic [`TRS_MS_W-1:0] scale_ms(
        input logic [`TRS_MS_W-1:0] base,
        input logic [`TRS_MS_W-1:0] mult
    );
        logic [2*`TRS_MS_W-1:0] prod;
        prod = base * mult;
        return prod[`TRS_MS_W-1:0];
    endfunction : scale_ms

    function automatic logic at_limit(
        input logic [`TRS_CNT_W-1:0] cnt,
        input int                    limit
    );
        logic [`TRS_CNT_W-1:0] lim;
        lim = `TRS_CNT_W'(limit);
        return cnt == lim;
    endfunction : at_limit

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // supply fault synchroniser and dip filter
    // ------------------------------------------------------------
    logic                  flt_meta;
    logic                  flt_sync;
    logic [`TRS_CNT_W-1:0] flt_cnt;
    logic                  fault_q;

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            flt_meta <= 1'b1;
            flt_sync <= 1'b1;
        end else begin
            flt_meta <= SUPPLY_FAULT_I;
            flt_sync <= flt_meta;
        end
    end

    wire flt_full = at_limit(flt_cnt, FILTER_CYCLES);

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            flt_cnt <= '0;
            fault_q <= 1'b1;
        end else if (!flt_sync) begin
            flt_cnt <= '0;
            fault_q <= 1'b0;
        end else if (flt_full) begin
            fault_q <= 1'b1;
        end else begin
            flt_cnt <= flt_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pushbutton debounce
    // ------------------------------------------------------------
    // the same count guards both edges, so a bounce on release
    // cannot cut a reset cycle short either
    logic                  manual_low;
    logic [`TRS_CNT_W-1:0] db_cnt;

    wire raw_low   = !MANUAL_RESET_N_I;
    wire db_differ = raw_low != manual_low;
    wire db_full   = at_limit(db_cnt, DEBOUNCE_CYCLES);

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            db_cnt     <= '0;
            manual_low <= 1'b0;
        end else if (!db_differ) begin
            db_cnt <= '0;
        end else if (db_full) begin
            db_cnt     <= '0;
            manual_low <= raw_low;
        end else begin
            db_cnt <= db_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // tolerance latch
    // ------------------------------------------------------------
    trs_tri_t tol_lvl;
    trs_tol_t next_tol;

    assign tol_lvl  = tri_decode(TOLERANCE_SELECT_I);
    assign next_tol = (tol_lvl == TRS_TRI_HIGH) ? TRS_TOL_5 :
                      (tol_lvl == TRS_TRI_LOW)  ? TRS_TOL_10 : TRS_TOL_15;

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            TOLERANCE_WINDOW_O <= TRS_TOL_15;
        end else if (SUPPLY_BELOW_MIN_I) begin
            TOLERANCE_WINDOW_O <= next_tol;
        end
    end

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    trs_state_t            state;
    trs_state_t            next_state;
    logic [`TRS_MS_W-1:0]  d1;
    logic [`TRS_MS_W-1:0]  elapsed;
    logic [`TRS_CNT_W-1:0] div_cnt;

    wire any_high = RESETS_N_O.first_reset_n | RESETS_N_O.second_reset_n
                  | RESETS_N_O.third_reset_n;
    wire manual_go = manual_low && (any_high || state == TRS_ST_MANUAL);

    wire [`TRS_MS_W-1:0] d2 = scale_ms(d1, `TRS_D2_MULT);
    wire [`TRS_MS_W-1:0] d3 = scale_ms(d1, `TRS_D3_MULT);
    wire                 seq_done = elapsed >= d3;
    wire                 start = (next_state == TRS_ST_WAIT)
                               && (state != TRS_ST_WAIT);

    always_comb begin
        next_state = state;
        case (state)
            TRS_ST_HOLD: begin
                if (!flt_sync) begin
                    next_state = TRS_ST_WAIT;
                end
            end
            TRS_ST_MANUAL: begin
                if (!manual_low) begin
                    next_state = TRS_ST_WAIT;
                end
            end
            TRS_ST_WAIT: begin
                if (seq_done) begin
                    next_state = TRS_ST_RUN;
                end
            end
            default: begin
                next_state = state;
            end
        endcase
        if (manual_go) begin
            next_state = TRS_ST_MANUAL;
        end
        if (fault_q) begin
            next_state = TRS_ST_HOLD;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state <= TRS_ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // delay select and timebase
    // ------------------------------------------------------------
    trs_tri_t            td_lvl;
    logic [`TRS_MS_W-1:0] next_d1;

    assign td_lvl  = tri_decode(DELAY_SELECT_I);
    assign next_d1 = (td_lvl == TRS_TRI_LOW)  ? `TRS_D1_LOW_MS :
                     (td_lvl == TRS_TRI_HIGH) ? `TRS_D1_HIGH_MS : `TRS_D1_OPEN_MS;

    // the setting is frozen per cycle so the three delays stay in ratio
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            d1 <= `TRS_D1_OPEN_MS;
        end else if (start) begin
            d1 <= next_d1;
        end
    end

    wire tick = at_limit(div_cnt, TICK_CYCLES - 1);

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
            elapsed <= `TRS_MS_ZERO;
        end else if (start || state != TRS_ST_WAIT) begin
            div_cnt <= '0;
            elapsed <= `TRS_MS_ZERO;
        end else if (tick) begin
            div_cnt <= '0;
            elapsed <= elapsed + 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // reset outputs
    // ------------------------------------------------------------
    trs_resets_t next_resets;
    wire         waiting = state == TRS_ST_WAIT;
    wire         running = state == TRS_ST_RUN;

    assign next_resets.first_reset_n  = running || (waiting && elapsed >= d1);
    assign next_resets.second_reset_n = running || (waiting && elapsed >= d2);
    assign next_resets.third_reset_n  = running || (waiting && seq_done);

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            RESETS_N_O <= '0;
        end else begin
            RESETS_N_O <= next_resets;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!rst_n);

    AST_FAULT_LOW: assert property (
        fault_q |=> ##1 (RESETS_N_O == '0))
        else $error("fault did not force all resets low");

    AST_FIRST_HELD: assert property (
        (waiting && elapsed < d1) |=> !RESETS_N_O.first_reset_n)
        else $error("first reset released early");

    AST_FIRST_FREED: assert property (
        (waiting && elapsed >= d1 && !fault_q && !manual_go)
        |=> RESETS_N_O.first_reset_n)
        else $error("first reset not released");

    AST_ORDER: assert property (
        RESETS_N_O.third_reset_n |-> RESETS_N_O.second_reset_n
        && RESETS_N_O.first_reset_n)
        else $error("reset release order broken");

    AST_STAY_HIGH: assert property (
        (running && !fault_q && !manual_low) |=> running)
        else $error("run state left without cause");

    AST_POWER_UP: assert property (
        $rose(rst_n) |-> (state == TRS_ST_HOLD) && fault_q)
        else $error("not holding after power-up");

    AST_TOL_FROZEN: assert property (
        !$past(SUPPLY_BELOW_MIN_I) |-> $stable(TOLERANCE_WINDOW_O))
        else $error("tolerance changed above trip");

    AST_TOL_HIGH: assert property (
        (SUPPLY_BELOW_MIN_I && TOLERANCE_SELECT_I == TRS_TRI_HIGH)
        |=> TOLERANCE_WINDOW_O == TRS_TOL_5)
        else $error("tolerance high not 5 percent");

    AST_MANUAL_TAKE: assert property (
        (running && manual_low && !fault_q) |=> state == TRS_ST_MANUAL)
        else $error("pushbutton not accepted");

    AST_MANUAL_LOW: assert property (
        (state == TRS_ST_MANUAL) |=> RESETS_N_O == '0)
        else $error("resets high during pushbutton");

    AST_MANUAL_GO: assert property (
        (state == TRS_ST_MANUAL && !manual_low && !fault_q)
        |=> waiting && elapsed == `TRS_MS_ZERO)
        else $error("release did not start sequence");

    AST_DEBOUNCE: assert property (
        $changed(manual_low) |-> at_limit($past(db_cnt), DEBOUNCE_CYCLES))
        else $error("debounce flipped before threshold");

    AST_D1_LOW: assert property (
        start && DELAY_SELECT_I == TRS_TRI_LOW |=> d1 == `TRS_D1_LOW_MS)
        else $error("wrong first delay for low select");

    AST_SECOND_AT: assert property (
        $rose(RESETS_N_O.second_reset_n) && $past(waiting)
        |-> $past(elapsed) == scale_ms(d1, `TRS_D2_MULT))
        else $error("second delay not five times first");

    AST_TICK: assert property (
        (waiting && tick && !start) |=> div_cnt == '0)
        else $error("divider did not wrap on tick");

    AST_FILTER: assert property (
        $rose(fault_q) |-> at_limit($past(flt_cnt), FILTER_CYCLES))
        else $error("fault taken before dip filter expired");

    COV_FULL_RUN: cover property (
        waiting ##1 running);
    COV_MANUAL: cover property (
        running ##1 state == TRS_ST_MANUAL);
    COV_FAULT: cover property (
        running ##1 state == TRS_ST_HOLD);

endmodule : trs_sequencer

// ==== tb/three_stage_reset_sequencer_bench.sv ====
`timescale 1ns/1ps

module three_stage_reset_sequencer_bench;
    import trs_pkg::*;

    // short counts so the longest sequence stays near 15000 cycles
    localparam int TICK = 20;
    localparam int DEB  = 30;
    localparam int FLT  = 40;

    logic        clk;
    logic        rst_n;
    logic        fault;
    logic        below_min;
    logic        press;
    logic        bounce;
    logic        manual_n;
    trs_tri_t    delay_sel;
    trs_tri_t    tol_sel;
    trs_tol_t    tol_win;
    trs_resets_t resets_n;
    int          cyc;
    int          rise_cyc [3];
    int          fall_cyc [3];
    int          fail_count;
    int          tests_run;
    int          t0;

    trs_sequencer #(.TICK_CYCLES(TICK), .DEBOUNCE_CYCLES(DEB), .FILTER_CYCLES(FLT))
        trs_sequencer_i (
        .CORE_CLK_I         (clk),
        .RESET_N_I          (rst_n),
        .SUPPLY_FAULT_I     (fault),
        .SUPPLY_BELOW_MIN_I (below_min),
        .MANUAL_RESET_N_I   (manual_n),
        .DELAY_SELECT_I     (delay_sel),
        .TOLERANCE_SELECT_I (tol_sel),
        .TOLERANCE_WINDOW_O (tol_win),
        .RESETS_N_O         (resets_n)
    );

    trs_system_model trs_system_model_i (
        .clk_i            (clk),
        .resets_n_i       (resets_n),
        .press_i          (press),
        .bounce_i         (bounce),
        .manual_reset_n_o (manual_n),
        .cyc_o            (cyc),
        .rise_cyc_o       (rise_cyc),
        .fall_cyc_o       (fall_cyc)
    );

    always #12.5 clk = ~clk;

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // want is {first, second, third}; one extra edge lets the recorder catch up
    task automatic wait_resets(input logic [2:0] want, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(negedge clk);
            if (resets_n === want) begin
                @(negedge clk);
                return;
            end
        end
        fail_count++;
        $display("unexpected reset outputs: expected %0h, seen %0h", want, resets_n);
        end_of_test();
    endtask : wait_resets

    task automatic run_sequence(input trs_tri_t sel, input int lo_ms, input int hi_ms);
        int d;
        delay_sel = sel;
        @(negedge clk);
        fault = 1'b0;
        t0    = cyc;
        repeat (10) @(negedge clk);
        // a late change of the select must not stretch or cut this sequence
        delay_sel = (sel == TRS_TRI_HIGH) ? TRS_TRI_LOW : TRS_TRI_HIGH;
        wait_resets(3'h7, 10 * hi_ms * TICK + 200);
        d = rise_cyc[0] - t0;
        check("first delay window", d >= lo_ms * TICK && d <= hi_ms * TICK + 8, 1'b1);
        check("first delay maximum", d <= hi_ms * TICK + 8, 1'b1);
        check("release order", rise_cyc[0] < rise_cyc[1] && rise_cyc[1] < rise_cyc[2], 1'b1);
        check("delay ratio", (rise_cyc[1] - rise_cyc[0]) * 9, (rise_cyc[2] - rise_cyc[0]) * 4);
        check("common tick", (rise_cyc[2] - rise_cyc[0]) % TICK, 0);
        check("second delay span", (rise_cyc[1] - rise_cyc[0]) >= 4 * lo_ms * TICK, 1'b1);
    endtask : run_sequence

    task automatic fault_event;
        @(negedge clk);
        fault = 1'b1;
        wait_resets(3'h0, FLT + 40);
        check("joint assert second", fall_cyc[1], fall_cyc[0]);
        check("joint assert third", fall_cyc[2], fall_cyc[0]);
    endtask : fault_event

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_power_up;
        trs_tri_t sel [3] = '{TRS_TRI_HIGH, TRS_TRI_LOW, TRS_TRI_OPEN};
        trs_tol_t win [3] = '{TRS_TOL_5, TRS_TOL_10, TRS_TOL_15};
        check("resets held in reset", resets_n, 3'h0);
        check("window reset value", tol_win, TRS_TOL_15);
        for (int i = 0; i < 3; i++) begin
            tol_sel = sel[i];
            repeat (3) @(negedge clk);
            check("tolerance decode", tol_win, win[i]);
        end
        tol_sel = TRS_TRI_LOW;
        repeat (3) @(negedge clk);
        below_min = 1'b0;
        @(negedge clk);
        tol_sel = TRS_TRI_HIGH;
        repeat (5) @(negedge clk);
        check("tolerance frozen", tol_win, TRS_TOL_10);
        check("held until supply valid", resets_n, 3'h0);
        run_sequence(TRS_TRI_LOW, 10, 20);
        $display("test power_up done");
    endtask : test_power_up

    task automatic test_delays;
        fault_event();
        run_sequence(TRS_TRI_OPEN, 20, 40);
        fault_event();
        run_sequence(TRS_TRI_HIGH, 50, 100);
        $display("test delays done");
    endtask : test_delays

    task automatic test_dip;
        int f;
        f = fall_cyc[0];
        @(negedge clk);
        fault = 1'b1;
        repeat (FLT - 10) @(negedge clk);
        fault = 1'b0;
        repeat (200) @(negedge clk);
        check("dip ignored", resets_n, 3'h7);
        check("no fresh assert", fall_cyc[0], f);
        $display("test dip done");
    endtask : test_dip

    task automatic test_pushbutton;
        int p0;
        delay_sel = TRS_TRI_LOW;
        press     = 1'b1;
        repeat (10) @(negedge clk);
        press = 1'b0;
        repeat (80) @(negedge clk);
        check("short press ignored", resets_n, 3'h7);
        bounce = 1'b1;
        press  = 1'b1;
        p0     = cyc + 24;
        wait_resets(3'h0, 200);
        check("assert after stable low", fall_cyc[0] - p0 >= 20 && fall_cyc[0] - p0 <= 40, 1'b1);
        repeat (200) @(negedge clk);
        check("held while pressed", resets_n, 3'h0);
        press  = 1'b0;
        bounce = 1'b0;
        t0     = cyc;
        wait_resets(3'h4, 25 * TICK + DEB + 50);
        check("release after button", rise_cyc[0] - t0 >= 10 * TICK + DEB, 1'b1);
        press = 1'b1;
        p0    = cyc;
        wait_resets(3'h0, 100);
        check("press with partial release", fall_cyc[0] - p0 <= 40, 1'b1);
        check("debounce not early", fall_cyc[0] - p0 >= 20, 1'b1);
        press = 1'b0;
        wait_resets(3'h7, 200 * TICK + 200);
        check("full release again", resets_n, 3'h7);
        $display("test pushbutton done");
    endtask : test_pushbutton

    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        fault      = 1'b1;
        below_min  = 1'b1;
        press      = 1'b0;
        bounce     = 1'b0;
        delay_sel  = TRS_TRI_LOW;
        tol_sel    = TRS_TRI_OPEN;
        fail_count = 0;
        tests_run  = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        test_power_up();
        test_delays();
        test_dip();
        test_pushbutton();
        end_of_test();
    end
endmodule : three_stage_reset_sequencer_bench

// ==== tb/trs_system_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// processor side: pushbutton with pull-up, reset edge recorder
// ----------------------------------------------------------------
module trs_system_model (
    input  wire logic                 clk_i,
    input  wire trs_pkg::trs_resets_t resets_n_i,
    input  wire logic                 press_i,
    input  wire logic                 bounce_i,
    output logic                      manual_reset_n_o,
    output int                        cyc_o,
    output int                        rise_cyc_o [3],
    output int                        fall_cyc_o [3]
);
    import trs_pkg::*;

    logic [2:0] now_n;
    logic [2:0] last_n;
    int         press_cnt;

    // index 0 is the first reset, so the bench can order them simply
    assign now_n = {resets_n_i.third_reset_n, resets_n_i.second_reset_n,
                    resets_n_i.first_reset_n};

    initial begin
        cyc_o     = 0;
        press_cnt = 0;
        last_n    = 3'h0;
        for (int k = 0; k < 3; k++) begin
            rise_cyc_o[k] = 0;
            fall_cyc_o[k] = 0;
        end
    end

    always @(posedge clk_i) begin
        cyc_o     <= cyc_o + 1;
        last_n    <= now_n;
        press_cnt <= press_i ? press_cnt + 1 : 0;
        for (int k = 0; k < 3; k++) begin
            if (now_n[k] === 1'b1 && last_n[k] !== 1'b1) begin
                rise_cyc_o[k] <= cyc_o;
            end
            if (now_n[k] === 1'b0 && last_n[k] !== 1'b0) begin
                fall_cyc_o[k] <= cyc_o;
            end
        end
    end

    // contact bounce burst
    // released button sits at the pull-up level; bounce gives three 4-cycle
    // spikes, then the contact stays low from count 24 on
    assign manual_reset_n_o = !press_i || (bounce_i && press_cnt < 24 && press_cnt[2]);
endmodule : trs_system_model
